// ==== rtl/emc_pkg.sv ====
// Constants and types for the energy mode controller
// Functional notes
// - Run mode keeps processor executing and all peripheral clocks on.
// - Sleep stops processor clock; peripherals, DMA, reflex network, memory stay clocked.
// - Deep sleep stops high-frequency oscillator; 32.768 kHz oscillator keeps running.
// - Deep sleep retains processor state and RAM; power-on reset, brown-out stay active.
// - Stop also disables low-frequency oscillator; retention, resets, brown-out stay on.
// - Stop accepts wake-up from comparator, async interrupt, pulse counter, I2C.
// - Shutoff turns all off except pin reset, GPIO wake/retention, backup clock, POR.
// - Shutoff optionally keeps 512-byte retention memory alongside GPIO retention.
// - Shutoff exits only on POR, pin reset, GPIO wake-up or backup clock interrupt.
// - Any enabled wake-up trigger returns sleep, deep sleep or stop to run.
// - Wake from deep sleep or stop completes within 2 us.
// - Controller removes power from SRAM blocks software marks unused.
package emc_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int EMC_SRAM_BLOCKS = 4;
  localparam int EMC_RET_MEM_BYTES = 512;
  localparam int EMC_CLK_MHZ = 200;
  localparam int EMC_WAKE_MAX_NS = 2000;
  // Longest time rounds down
  localparam int EMC_WAKE_MAX_CYC = (EMC_WAKE_MAX_NS * EMC_CLK_MHZ) / 1000;
  // Oscillator restart budget, well inside the wake limit
  localparam int EMC_OSC_START_CYC = 16;
  localparam int EMC_RST_HOLD_CYC = 8;
  localparam logic [2:0] EMC_REQ_RESET = 3'h0;

  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [2:0] {
    EMC_RUN = 3'b000,
    EMC_SLEEP = 3'b001,
    EMC_DEEP = 3'b010,
    EMC_STOP = 3'b011,
    EMC_SHUTOFF = 3'b100,
    EMC_WAKE = 3'b101,
    EMC_RESTART = 3'b110
  } emc_state_type;

  // Software request codes
  localparam logic [2:0] EMC_REQ_SLEEP = 3'h1;
  localparam logic [2:0] EMC_REQ_DEEP = 3'h2;
  localparam logic [2:0] EMC_REQ_STOP = 3'h3;
  localparam logic [2:0] EMC_REQ_SHUTOFF = 3'h4;

endpackage

// ==== rtl/emc_top.sv ====
// Energy mode sequencer: mode state machine and power and clock gating outputs
`timescale 1ns/1ps
module emc_top
  import emc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_rst_n,
  input wire logic mode_req_valid,
  input wire logic [2:0] mode_req,
  input wire logic ret_mem_keep,
  input wire logic [EMC_SRAM_BLOCKS-1:0] sram_unused,
  input wire logic [3:0] wake_enable,
  input wire logic periph_wake,
  input wire logic comparator_wake,
  input wire logic async_irq_wake,
  input wire logic pulse_counter_wake,
  input wire logic i2c_wake,
  input wire logic gpio_wake,
  input wire logic backup_clock_irq,
  input wire logic hf_osc_ready,
  output logic [2:0] energy_mode,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic hf_osc_en,
  output logic lf_osc_en,
  output logic le_periph_en,
  output logic retention_en,
  output logic bod_en,
  output logic gpio_retain,
  output logic pins_to_reset,
  output logic ret_mem_pwr,
  output logic cpu_rst_n,
  output logic [EMC_SRAM_BLOCKS-1:0] sram_pwr_en
);

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  emc_state_type state_r, state_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic keep_r;
  logic [EMC_SRAM_BLOCKS-1:0] sram_pwr_r;

  // ----------------------------------------
  // Wake-up selection
  // ----------------------------------------
  // stop wake sources
  wire stop_wake = (wake_enable[0] & comparator_wake)
                 | (wake_enable[1] & async_irq_wake)
                 | (wake_enable[2] & pulse_counter_wake)
                 | (wake_enable[3] & i2c_wake);
  wire sleep_wake = stop_wake | periph_wake;
  // Pin reset only acts as a wake here; elsewhere the power-on reset covers it
  // shutoff exits
  wire shutoff_exit = ~pin_rst_n | gpio_wake | backup_clock_irq;
  wire cnt_done = (cnt_r == 8'h00);
  // Codes outside the low energy range are ignored without any indication
  wire req_in_range = (mode_req >= EMC_REQ_SLEEP) & (mode_req <= EMC_REQ_SHUTOFF);
  wire req_ok = mode_req_valid & req_in_range;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    // Counter parks at zero so an idle state never wraps it
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 8'h01;
    unique case (state_r)
      EMC_RUN: begin
        if (req_ok) begin
          mode_nxt = mode_req;
          unique case (mode_req)
            EMC_REQ_SLEEP: state_nxt = EMC_SLEEP;
            EMC_REQ_DEEP: state_nxt = EMC_DEEP;
            EMC_REQ_STOP: state_nxt = EMC_STOP;
            default: state_nxt = EMC_SHUTOFF;
          endcase
        end
      end
      EMC_SLEEP: begin
        if (sleep_wake) begin
          state_nxt = EMC_RUN;
          mode_nxt = EMC_REQ_RESET;
        end
      end
      EMC_DEEP, EMC_STOP: begin
        if ((state_r == EMC_DEEP) ? sleep_wake : stop_wake) begin
          state_nxt = EMC_WAKE;
          cnt_nxt = 8'(EMC_OSC_START_CYC);
        end
      end
      EMC_WAKE: begin
        if (hf_osc_ready | cnt_done) begin
          state_nxt = EMC_RUN;
          mode_nxt = EMC_REQ_RESET;
        end
      end
      EMC_SHUTOFF: begin
        if (shutoff_exit) begin
          state_nxt = EMC_RESTART;
          cnt_nxt = 8'(EMC_RST_HOLD_CYC);
        end
      end
      EMC_RESTART: begin
        if (cnt_done) begin
          state_nxt = EMC_RUN;
          mode_nxt = EMC_REQ_RESET;
        end
      end
      // Unused code falls back to run rather than locking up
      default: begin
        state_nxt = EMC_RUN;
        mode_nxt = EMC_REQ_RESET;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // energy_mode keeps showing the target mode through wake and restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= EMC_RUN;
      mode_r <= EMC_REQ_RESET;
      cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // Gating decode
  // ----------------------------------------
  wire n_run = (state_nxt == EMC_RUN);
  wire n_sleep = (state_nxt == EMC_SLEEP);
  wire n_deep = (state_nxt == EMC_DEEP);
  wire n_stop = (state_nxt == EMC_STOP);
  wire n_off = (state_nxt == EMC_SHUTOFF);
  wire n_wake = (state_nxt == EMC_WAKE);
  wire n_rst = (state_nxt == EMC_RESTART);
  wire cpu_en_nxt = n_run;
  wire periph_en_nxt = n_run | n_sleep;
  // Oscillator restarts ahead of run so the processor never sees a slow clock
  // high-frequency off
  wire hf_en_nxt = n_run | n_sleep | n_wake | n_rst;
  wire lf_en_nxt = ~(n_stop | n_off);
  wire le_en_nxt = n_run | n_sleep | n_deep;
  wire ret_en_nxt = n_deep | n_stop | n_wake;
  wire bod_en_nxt = ~n_off;
  wire gpio_ret_nxt = n_off;
  // Keep choice latched at entry; the pin may move while asleep
  // optional retention memory
  wire keep_nxt = (state_r == EMC_RUN && req_ok) ? ret_mem_keep : keep_r;
  wire ret_mem_nxt = ~n_off | keep_nxt;
  // Shutoff drops every block; retention memory is the only kept storage
  // unused SRAM off; all lost in shutoff
  wire [EMC_SRAM_BLOCKS-1:0] sram_nxt = n_off ? '0 : ~sram_unused;

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Reset holds the processor until the first edge after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b1;
      hf_osc_en <= 1'b1;
      lf_osc_en <= 1'b1;
      le_periph_en <= 1'b1;
      retention_en <= 1'b0;
      bod_en <= 1'b1;
      gpio_retain <= 1'b0;
      pins_to_reset <= 1'b1;
      ret_mem_pwr <= 1'b1;
      cpu_rst_n <= 1'b0;
      keep_r <= 1'b0;
      sram_pwr_r <= '1;
      energy_mode <= EMC_REQ_RESET;
    end else begin
      cpu_clk_en <= cpu_en_nxt;
      periph_clk_en <= periph_en_nxt;
      hf_osc_en <= hf_en_nxt;
      lf_osc_en <= lf_en_nxt;
      le_periph_en <= le_en_nxt;
      retention_en <= ret_en_nxt;
      bod_en <= bod_en_nxt;
      gpio_retain <= gpio_ret_nxt;
      pins_to_reset <= n_off | n_rst;
      ret_mem_pwr <= ret_mem_nxt;
      cpu_rst_n <= ~(n_off | n_rst);
      keep_r <= keep_nxt;
      sram_pwr_r <= sram_nxt;
      energy_mode <= mode_nxt;
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign sram_pwr_en = sram_pwr_r;

endmodule

// ==== verif/emc_top_monitor.sv ====
// Port-level checks for the energy mode controller
`timescale 1ns/1ps
module emc_top_monitor
  import emc_pkg::*;
(
  input wire logic clk, input wire logic rst_n, input wire logic pin_rst_n,
  input wire logic ret_mem_keep, input wire logic [3:0] wake_enable,
  input wire logic comparator_wake, input wire logic gpio_wake, input wire logic backup_clock_irq,
  input wire logic [2:0] energy_mode, input wire logic cpu_clk_en, input wire logic periph_clk_en,
  input wire logic hf_osc_en, input wire logic lf_osc_en, input wire logic retention_en,
  input wire logic bod_en, input wire logic gpio_retain, input wire logic pins_to_reset,
  input wire logic ret_mem_pwr, input wire logic cpu_rst_n, input wire logic [3:0] sram_pwr_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // No shutoff exit cause present
  wire quiet = pin_rst_n && !gpio_wake && !backup_clock_irq;
  run_clk_a: assert property (energy_mode == 3'h0 && cpu_rst_n |-> cpu_clk_en && hf_osc_en)
    else $error("run clocks off");
  sleep_clk_a: assert property (energy_mode == 3'h1 |-> !cpu_clk_en && periph_clk_en)
    else $error("sleep clocks wrong");
  deep_osc_a: assert property (energy_mode == 3'h2 && !hf_osc_en |->
    !cpu_clk_en && lf_osc_en && retention_en && bod_en) else $error("deep sleep wrong");
  stop_osc_a: assert property (energy_mode == 3'h3 && !hf_osc_en |->
    !lf_osc_en && retention_en && bod_en) else $error("stop wrong");
  shut_state_a: assert property ($rose(energy_mode == 3'h4) |-> gpio_retain && pins_to_reset
    && sram_pwr_en == 4'h0 && ret_mem_pwr == $past(ret_mem_keep)) else $error("shutoff wrong");
  shut_stay_a: assert property ($rose(energy_mode == 3'h4) ##1 quiet [*8] |->
    ##3 energy_mode == 3'h4 && !cpu_clk_en) else $error("shutoff left early");
  restart_seq_a: assert property (energy_mode == 3'h4 && gpio_retain && gpio_wake |=>
    !cpu_rst_n [*8] ##[1:3] cpu_rst_n && cpu_clk_en) else $error("restart wrong");
  wake_time_a: assert property (energy_mode inside {3'h2, 3'h3} && comparator_wake
    && wake_enable[0] |-> ##[1:400] energy_mode == 3'h0 && cpu_clk_en) else $error("wake slow");
  cover property (energy_mode == 3'h1 ##1 energy_mode == 3'h0);
  cover property (energy_mode == 3'h3 ##1 energy_mode == 3'h0);
  cover property ($rose(energy_mode == 3'h4));
endmodule
bind emc_top emc_top_monitor u_mon (.*);

// ==== verif/emc_top_tb.sv ====
// Self-checking bench for the energy mode controller
`timescale 1ns/1ps
module emc_top_tb;
  import emc_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, pin_rst_n = 1'h1, mode_req_valid = 1'h0, ret_mem_keep = 1'h0;
  logic comparator_wake = 1'h0, async_irq_wake = 1'h0, pulse_counter_wake = 1'h0;
  logic i2c_wake = 1'h0, gpio_wake = 1'h0, backup_clock_irq = 1'h0, hf_osc_ready = 1'h0;
  logic periph_wake = 1'h0;
  logic [2:0] mode_req = 3'h0, energy_mode;
  logic [3:0] sram_unused = 4'h5, wake_enable = 4'h0, sram_pwr_en;
  logic cpu_clk_en, periph_clk_en, hf_osc_en, lf_osc_en, le_periph_en, retention_en, bod_en;
  logic gpio_retain, pins_to_reset, ret_mem_pwr, cpu_rst_n;
  int errors = 0;
  int tests_run = 0;
  emc_top uut (.*);
  initial forever #2.5 clk = ~clk;
  task automatic give_verdict;
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic req(input logic [2:0] code, input logic keep);
    @(posedge clk);
    {mode_req, ret_mem_keep, mode_req_valid} <= {code, keep, 1'h1};
    @(posedge clk);
    mode_req_valid <= 1'h0;
    #1;
  endtask
  task automatic wk(input logic [3:0] w);
    @(posedge clk);
    {i2c_wake, pulse_counter_wake, async_irq_wake, comparator_wake} <= w;
  endtask
  // Bounded wait for run, cycle count judged
  task automatic go_run(input int lo, input int hi);
    int n;
    n = 0;
    while (n < 500 && !(energy_mode === 3'h0 && cpu_clk_en === 1'h1)) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wake_time", 8'h1, {7'h0, n >= lo && n <= hi});
  endtask
  task automatic t_sleep;
    chk("run_outs", 8'h1E, {3'h0, cpu_clk_en, periph_clk_en, hf_osc_en, cpu_rst_n, pins_to_reset});
    chk("sram_pwr", 8'h0A, {4'h0, sram_pwr_en});
    sram_unused <= 4'h3;
    repeat (2) @(posedge clk);
    #1;
    chk("sram_follow", 8'h0C, {4'h0, sram_pwr_en});
    req(EMC_REQ_SLEEP, 1'h0);
    chk("sleep_clk", 8'h05, {3'h0, energy_mode, cpu_clk_en, periph_clk_en});
    req(EMC_REQ_STOP, 1'h0);
    chk("refused", 8'h1, {5'h0, energy_mode});
    wake_enable <= 4'h1;
    wk(4'h1);
    go_run(1, 2);
    wk(4'h0);
    req(EMC_REQ_DEEP, 1'h0);
    chk("deep_osc", 8'h7, {3'h0, cpu_clk_en, hf_osc_en, lf_osc_en, retention_en, bod_en});
    chk("deep_le", 8'h01, {7'h0, le_periph_en});
    wk(4'h1);
    go_run(2, 400);
    wk(4'h0);
  endtask
  task automatic t_stop;
    for (int i = 0; i < 4; i++) begin
      wake_enable <= 4'h0;
      req(EMC_REQ_STOP, 1'h0);
      chk("stop_osc", 8'h3, {4'h0, hf_osc_en, lf_osc_en, retention_en, bod_en});
      wk(4'(1 << i));
      repeat (20) @(posedge clk);
      #1;
      chk("stop_hold", 8'h3, {5'h0, energy_mode});
      @(posedge clk);
      wake_enable <= 4'(1 << i);
      hf_osc_ready <= (i == 3);
      go_run(2, (i == 3) ? 3 : 400);
      hf_osc_ready <= 1'h0;
      wk(4'h0);
    end
  endtask
  task automatic t_shut;
    logic [2:0] ex [3] = '{3'h5, 3'h6, 3'h0};
    for (int k = 0; k < 3; k++) begin
      req(EMC_REQ_SHUTOFF, k[0]);
      chk("shut_outs", {2'h3, k[0], 5'h0}, {gpio_retain, pins_to_reset, ret_mem_pwr, cpu_clk_en, sram_pwr_en});
      chk("shut_off", 8'h00, {3'h0, hf_osc_en, lf_osc_en, le_periph_en, bod_en, periph_clk_en});
      wk(4'h1);
      repeat (20) @(posedge clk);
      {pin_rst_n, backup_clock_irq, gpio_wake} <= ex[k];
      #1;
      chk("shut_hold", 8'h4, {5'h0, energy_mode});
      @(posedge clk);
      {pin_rst_n, backup_clock_irq, gpio_wake} <= 3'h4;
      #1;
      chk("restart", 8'h2, {6'h0, pins_to_reset, cpu_rst_n});
      go_run(6, 12);
      wk(4'h0);
    end
  endtask
  // Run needs about 310 cycles; generous margin
  initial begin
    #50000;
    errors++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    t_sleep;
    t_stop;
    t_shut;
    give_verdict;
  end
endmodule
